// ===== cpa_channel_attach.sv
// Functional notes
// - While force-instruction is up, data-service requests are not granted.
// - Hang before I/O interface: logout, status store, machine reset.
// - Hang after I/O interface: selective reset, logout, status store.
// - Channel-reset pulse causes a machine reset clearing all state except the synchronisers and data pipeline.
// - Channel reset with a device operating also gives selective reset.
// - Control-transmit accompanies select; only the selected channel acts.
// - Decode four instruction bits into the eight listed instructions.
// - Halt device runs as halt, fast start runs as start.
// - Store identification writes type/model to 168-169, zeros 170-171.
// - Identity word: 4-bit type, 12-bit model, zero means implied.
// - Control bus: 010 blocks requests, 011 timeout, 100 full reset.
// - Store identification condition codes 0 ok, 1 check, 2 busy, 3 n/a.
`timescale 1ns/1ps
module cpa_channel_attach #(
    // Arbitrary value
    parameter logic [11:0] CHAN_MODEL = 12'h000
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Adapter and processor lines
    input wire logic force_instr,
    input wire logic hang_detect,
    input wire logic chan_reset_pulse,
    input wire logic select_channel,
    input wire logic intr_response,
    input wire logic ctrl_transmit,
    input wire logic [4:0] instruction_code_bus,
    input wire logic [2:0] ctrl_bus,
    // Storage return lines
    input wire logic storage_advance_strobe,
    input wire logic [cpa_pkg::DATA_W-1:0] storage_return_data,
    input wire logic [3:0] storage_checks,
    // Multiplex interface and channel core
    input wire logic request_in,
    input wire logic at_io_interface,
    input wire logic device_operating,
    input wire logic iface_busy,
    input wire logic chan_available,
    // Request grant and decoded instruction
    output logic data_req_grant,
    output logic block_requests,
    output logic instr_strobe,
    output logic [3:0] instr_op,
    output logic ctrl_check,
    output logic cc_valid,
    output logic [1:0] cond_code,
    // Identification store
    output logic id_store_strobe,
    output logic [7:0] id_store_addr,
    output logic [31:0] id_store_data,
    // Termination sequence
    output logic do_logout,
    output logic do_csw_store,
    output logic do_machine_reset,
    output logic do_selective_reset,
    // Storage return
    output logic ret_valid,
    output logic [cpa_pkg::DATA_W-1:0] ret_data,
    output logic [3:0] ret_checks
);
    cpa_pkg::cpa_regs_s r;
    cpa_pkg::cpa_regs_s n;
    logic [cpa_pkg::SYNC_W-1:0] async_in;
    logic [cpa_pkg::SYNC_W-1:0] rise;
    logic [cpa_pkg::SYNC_W-1:0] agree;
    logic [4:0] ins;
    logic [3:0] op;
    logic start_hang;
    logic reset_all;

    function automatic logic [3:0] cpa_canon(input logic [3:0] c);
        logic [3:0] o;
        o = c;
        if (c == cpa_pkg::OP_HALT_DEV) begin
            o = cpa_pkg::OP_HALT;
        end
        if (c == cpa_pkg::OP_FAST) begin
            o = cpa_pkg::OP_START;
        end
        return o;
    endfunction

    assign async_in = {instruction_code_bus, ctrl_bus, storage_checks,
                       storage_advance_strobe, ctrl_transmit,
                       intr_response, select_channel, chan_reset_pulse,
                       hang_detect, force_instr, request_in};
    assign rise = r.filt & ~r.prev;
    assign agree = ~(r.s2 ^ r.s3);
    assign ins = r.filt[cpa_pkg::I_INS +: 5];
    assign op = cpa_canon(ins[3:0]);

    always_comb begin
        n = r;
        start_hang = 1'b0;
        reset_all = 1'b0;
        n.instr_strobe = 1'b0;
        n.ctrl_check = 1'b0;
        n.cc_valid = 1'b0;
        n.id_strobe = 1'b0;
        n.ret_valid = 1'b0;
        n.grant = r.filt[cpa_pkg::I_REQ] & ~r.filt[cpa_pkg::I_FRC] & ~r.blk;
        if (!r.filt[cpa_pkg::I_SEL]) begin
            n.blk = 1'b0;
        end
        if (rise[cpa_pkg::I_SEL]) begin
            if (r.filt[cpa_pkg::I_CTX]) begin
                unique case (r.filt[cpa_pkg::I_CTL +: 3])
                    cpa_pkg::CB_BLOCK: n.blk = 1'b1;
                    cpa_pkg::CB_TIMEOUT: start_hang = 1'b1;
                    cpa_pkg::CB_RESET: reset_all = 1'b1;
                    default: ;
                endcase
            end else if (!(^ins)) begin
                n.ctrl_check = 1'b1;
                n.cc = cpa_pkg::CC_CHECK;
                n.cc_valid = 1'b1;
            end else begin
                n.instr_strobe = 1'b1;
                n.instr_op = op;
                if (op == cpa_pkg::OP_STORE_ID) begin
                    n.cc_valid = 1'b1;
                    if (!chan_available) begin
                        n.cc = cpa_pkg::CC_NA;
                    end else if (iface_busy) begin
                        n.cc = cpa_pkg::CC_BUSY;
                    end else begin
                        n.cc = cpa_pkg::CC_OK;
                        n.id_strobe = 1'b1;
                        n.id_data = {cpa_pkg::ID_TYPE_BYTE_MPX, CHAN_MODEL,
                                     cpa_pkg::ID_PAD};
                    end
                end
            end
        end
        if (rise[cpa_pkg::I_HANG]) begin
            start_hang = 1'b1;
        end
        // A hang while a sequence runs is dropped; one sequence is enough
        unique case (r.st)
            cpa_pkg::ST_IDLE: begin
                if (start_hang) begin
                    n.via_io = at_io_interface;
                    n.st = at_io_interface ? cpa_pkg::ST_SEL
                                           : cpa_pkg::ST_LOG;
                end
            end
            cpa_pkg::ST_SEL: n.st = cpa_pkg::ST_LOG;
            cpa_pkg::ST_LOG: n.st = cpa_pkg::ST_CSW;
            cpa_pkg::ST_CSW: begin
                n.st = r.via_io ? cpa_pkg::ST_IDLE : cpa_pkg::ST_MRST;
            end
            cpa_pkg::ST_MRST: n.st = cpa_pkg::ST_IDLE;
            default: n.st = cpa_pkg::ST_IDLE;
        endcase
        n.srst = (n.st == cpa_pkg::ST_SEL);
        n.logout = (n.st == cpa_pkg::ST_LOG);
        n.channel_status_word = (n.st == cpa_pkg::ST_CSW);
        n.mrst = (n.st == cpa_pkg::ST_MRST);
        if (rise[cpa_pkg::I_ADV]) begin
            n.cnt = cpa_pkg::DATA_DLY;
            n.chk = r.filt[cpa_pkg::I_CHK +: 4];
        end else if (r.cnt != '0) begin
            n.cnt = r.cnt - cpa_pkg::CNT_LAST;
            n.chk = r.chk | r.filt[cpa_pkg::I_CHK +: 4];
            if (r.cnt == cpa_pkg::CNT_LAST) begin
                n.ret_valid = 1'b1;
                n.ret_data = r.d3;
                n.ret_chk = n.chk;
            end
        end
        if (rise[cpa_pkg::I_CRST] || reset_all) begin
            n = '0;
            n.mrst = 1'b1;
            n.srst = device_operating | reset_all;
        end
        // Synchronisers survive a channel reset so edges stay coherent
        n.s1 = async_in;
        n.s2 = r.s1;
        n.s3 = r.s2;
        n.filt = (agree & r.s3) | (~agree & r.filt);
        n.prev = r.filt;
        n.d1 = storage_return_data;
        n.d2 = r.d1;
        n.d3 = r.d2;
        n.id_addr = cpa_pkg::ID_ADDR;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign data_req_grant = r.grant;
    assign block_requests = r.blk;
    assign instr_strobe = r.instr_strobe;
    assign instr_op = r.instr_op;
    assign ctrl_check = r.ctrl_check;
    assign cc_valid = r.cc_valid;
    assign cond_code = r.cc;
    assign id_store_strobe = r.id_strobe;
    assign id_store_addr = r.id_addr;
    assign id_store_data = r.id_data;
    assign do_logout = r.logout;
    assign do_csw_store = r.channel_status_word;
    assign do_machine_reset = r.mrst;
    assign do_selective_reset = r.srst;
    assign ret_valid = r.ret_valid;
    assign ret_data = r.ret_data;
    assign ret_checks = r.ret_chk;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    logic quiet;
    assign quiet = !rise[cpa_pkg::I_CRST] && !rise[cpa_pkg::I_SEL];

    property p_grant_blocked;
        r.grant |-> !$past(r.filt[cpa_pkg::I_FRC]);
    endproperty
    a_grant_blocked: assert property (p_grant_blocked)
        else $error("grant while force active");

    property p_hang_noio;
        rise[cpa_pkg::I_HANG] && r.st == cpa_pkg::ST_IDLE && quiet
            && !at_io_interface
            ##1 quiet
            |-> r.logout ##1 r.channel_status_word ##1 r.mrst;
    endproperty
    a_hang_noio: assert property (p_hang_noio)
        else $error("bad hang sequence before interface");

    property p_hang_io;
        rise[cpa_pkg::I_HANG] && r.st == cpa_pkg::ST_IDLE && quiet
            && at_io_interface
            ##1 quiet [*2]
            |-> $past(r.srst) && r.logout ##1 r.channel_status_word;
    endproperty
    a_hang_io: assert property (p_hang_io)
        else $error("bad hang sequence on interface");

    property p_crst;
        rise[cpa_pkg::I_CRST] |=> r.mrst && !r.blk && r.cnt == '0;
    endproperty
    a_crst: assert property (p_crst)
        else $error("channel reset did not clear");

    property p_crst_sel;
        rise[cpa_pkg::I_CRST] && device_operating |=> r.srst;
    endproperty
    a_crst_sel: assert property (p_crst_sel)
        else $error("no selective reset");

    property p_block_sel;
        $rose(r.blk) |-> $past(r.filt[cpa_pkg::I_CTX])
            && $past(rise[cpa_pkg::I_SEL]);
    endproperty
    a_block_sel: assert property (p_block_sel)
        else $error("block without selection");

    property p_alias;
        r.instr_strobe |-> r.instr_op != cpa_pkg::OP_HALT_DEV
            && r.instr_op != cpa_pkg::OP_FAST;
    endproperty
    a_alias: assert property (p_alias)
        else $error("alias code not mapped");

    property p_id_word;
        r.id_strobe |-> r.id_addr == cpa_pkg::ID_ADDR
            && r.id_data[15:0] == cpa_pkg::ID_PAD
            && r.id_data[31:28] == cpa_pkg::ID_TYPE_BYTE_MPX
            && r.cc == cpa_pkg::CC_OK && r.cc_valid;
    endproperty
    a_id_word: assert property (p_id_word)
        else $error("bad identity store");

    property p_parity;
        rise[cpa_pkg::I_SEL] && !r.filt[cpa_pkg::I_CTX] && !(^ins)
            && !rise[cpa_pkg::I_CRST]
            |=> r.ctrl_check && r.cc == cpa_pkg::CC_CHECK && !r.instr_strobe;
    endproperty
    a_parity: assert property (p_parity)
        else $error("parity error not flagged");

    property p_ret_delay;
        rise[cpa_pkg::I_ADV] && !rise[cpa_pkg::I_CRST]
            ##1 !rise[cpa_pkg::I_ADV] && quiet [*8]
            ##1 !rise[cpa_pkg::I_ADV] && quiet [*2]
            |=> r.ret_valid;
    endproperty
    a_ret_delay: assert property (p_ret_delay)
        else $error("return data not captured");

    c_store_id: cover property (r.id_strobe);
    c_hang: cover property (r.st == cpa_pkg::ST_MRST);
    c_ret_chk: cover property (r.ret_valid && r.ret_chk != '0);
    c_block: cover property (r.blk && r.filt[cpa_pkg::I_REQ]);
endmodule

// ===== cpa_pkg.sv
package cpa_pkg;
    // Timing
    localparam int CLK_NS = 10;
    localparam int DATA_DLY_NS = 100;
    localparam int DATA_DLY_CYC = (DATA_DLY_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] DATA_DLY = CNT_W'(DATA_DLY_CYC);
    localparam logic [CNT_W-1:0] CNT_LAST = 4'h1;
    // Positions in the synchronised control vector
    localparam int I_REQ = 0;
    localparam int I_FRC = 1;
    localparam int I_HANG = 2;
    localparam int I_CRST = 3;
    localparam int I_SEL = 4;
    localparam int I_IRSP = 5;
    localparam int I_CTX = 6;
    localparam int I_ADV = 7;
    localparam int I_CHK = 8;
    localparam int I_CTL = 12;
    localparam int I_INS = 15;
    localparam int SYNC_W = 20;
    localparam int DATA_W = 72;
    // Instruction codes
    localparam logic [3:0] OP_IPL = 4'h2;
    localparam logic [3:0] OP_START = 4'h4;
    localparam logic [3:0] OP_TEST = 4'h5;
    localparam logic [3:0] OP_HALT = 4'h6;
    localparam logic [3:0] OP_TCH = 4'h7;
    localparam logic [3:0] OP_HALT_DEV = 4'he;
    localparam logic [3:0] OP_FAST = 4'hc;
    localparam logic [3:0] OP_STORE_ID = 4'hf;
    // Control bus functions
    localparam logic [2:0] CB_BLOCK = 3'h2;
    localparam logic [2:0] CB_TIMEOUT = 3'h3;
    localparam logic [2:0] CB_RESET = 3'h4;
    // Condition codes
    localparam logic [1:0] CC_OK = 2'h0;
    localparam logic [1:0] CC_CHECK = 2'h1;
    localparam logic [1:0] CC_BUSY = 2'h2;
    localparam logic [1:0] CC_NA = 2'h3;
    // Identification store
    localparam logic [7:0] ID_ADDR = 8'ha8;
    localparam logic [3:0] ID_TYPE_BYTE_MPX = 4'h1;
    localparam logic [15:0] ID_PAD = 16'h0000;

    typedef enum logic [2:0] {
        ST_IDLE, ST_SEL, ST_LOG, ST_CSW, ST_MRST
    } cpa_state_e;

    typedef struct packed {
        logic [SYNC_W-1:0] s1;
        logic [SYNC_W-1:0] s2;
        logic [SYNC_W-1:0] s3;
        logic [SYNC_W-1:0] filt;
        logic [SYNC_W-1:0] prev;
        logic [DATA_W-1:0] d1;
        logic [DATA_W-1:0] d2;
        logic [DATA_W-1:0] d3;
        cpa_state_e st;
        logic via_io;
        logic blk;
        logic [CNT_W-1:0] cnt;
        logic [3:0] chk;
        logic grant;
        logic instr_strobe;
        logic [3:0] instr_op;
        logic ctrl_check;
        logic cc_valid;
        logic [1:0] cc;
        logic id_strobe;
        logic [7:0] id_addr;
        logic [31:0] id_data;
        logic logout;
        logic channel_status_word;
        logic mrst;
        logic srst;
        logic ret_valid;
        logic [DATA_W-1:0] ret_data;
        logic [3:0] ret_chk;
    } cpa_regs_s;
endpackage

// ===== cpa_partner.sv
`timescale 1ns/1ps
module cpa_partner (
    // Clock
    input wire logic clock,
    // Processor lines
    output logic select_channel,
    output logic intr_response,
    output logic ctrl_transmit,
    output logic [4:0] instruction_code_bus,
    output logic [2:0] ctrl_bus,
    // Storage return lines
    output logic storage_advance_strobe,
    output logic [cpa_pkg::DATA_W-1:0] storage_return_data,
    output logic [3:0] storage_checks
);
    initial begin
        select_channel = 1'b0;
        intr_response = 1'b0;
        ctrl_transmit = 1'b0;
        instruction_code_bus = 5'h00;
        ctrl_bus = 3'h0;
        storage_advance_strobe = 1'b0;
        storage_return_data = '0;
        storage_checks = 4'h0;
    end

    // One selection frame; bad_par breaks the odd parity on purpose
    task automatic issue(input logic [3:0] code, input logic bad_par,
        input logic ctx, input logic [2:0] cb);
        @(posedge clock);
        // Lines settle 150 ns before select
        intr_response <= 1'b1;
        instruction_code_bus <= {~^code ^ bad_par, code};
        ctrl_bus <= cb;
        repeat (15) @(posedge clock);
        select_channel <= 1'b1;
        ctrl_transmit <= ctx;
        repeat (10) @(posedge clock);
        select_channel <= 1'b0;
        ctrl_transmit <= 1'b0;
        repeat (8) @(posedge clock);
        intr_response <= 1'b0;
        // Released lines must not keep looking like the last code
        instruction_code_bus <= ~instruction_code_bus;
        ctrl_bus <= ~ctrl_bus;
    endtask

    task automatic advance(input logic [cpa_pkg::DATA_W-1:0] d,
        input logic [3:0] chk);
        @(posedge clock);
        storage_advance_strobe <= 1'b1;
        storage_checks <= chk;
        repeat (10) @(posedge clock);
        // Data 100 ns after the strobe
        storage_return_data <= d;
        repeat (10) @(posedge clock);
        storage_advance_strobe <= 1'b0;
        repeat (25) @(posedge clock);
        storage_checks <= 4'h0;
        storage_return_data <= ~d;
    endtask
endmodule

// ===== tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
    miscompares++; $display("unexpected %s exp=%0h got=%0h", nm, e, g); \
    end end
module tb_top;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic force_instr = 1'b0, hang_detect = 1'b0, chan_reset_pulse = 1'b0;
    logic request_in = 1'b0, at_io_interface = 1'b0, iface_busy = 1'b0;
    logic device_operating = 1'b0, chan_available = 1'b1;
    logic select_channel, intr_response, ctrl_transmit, storage_advance_strobe;
    logic [4:0] instruction_code_bus;
    logic [2:0] ctrl_bus;
    logic [cpa_pkg::DATA_W-1:0] storage_return_data, ret_data, dv;
    logic [3:0] storage_checks, ret_checks, instr_op, cv;
    logic data_req_grant, block_requests, instr_strobe, ctrl_check, cc_valid;
    logic id_store_strobe, do_logout, do_csw_store, do_machine_reset;
    logic do_selective_reset, ret_valid, saw_block = 1'b0, blk_d = 1'b0;
    logic [1:0] cond_code;
    logic [7:0] id_store_addr, ev;
    logic [31:0] id_store_data;
    logic [95:0] rv;
    logic [3:0] codes [8] = '{4'h2, 4'h4, 4'h5, 4'h6, 4'h7, 4'he, 4'hc, 4'hf};
    logic [1:0] ccs [3] = '{2'h0, 2'h2, 2'h3};
    int miscompares = 0, tests_run = 0, cyc = 0, bad_grant = 0, cc_pulses = 0;
    int log_q[$], cyc_q[$], exp_q[$];
    int unsigned seed = 32;

    always #5 clock = ~clock;

    cpa_channel_attach dut_u (.clock(clock), .rst_n(rst_n),
        .force_instr(force_instr), .hang_detect(hang_detect),
        .chan_reset_pulse(chan_reset_pulse), .select_channel(select_channel),
        .intr_response(intr_response), .ctrl_transmit(ctrl_transmit),
        .instruction_code_bus(instruction_code_bus), .ctrl_bus(ctrl_bus),
        .storage_advance_strobe(storage_advance_strobe),
        .storage_return_data(storage_return_data),
        .storage_checks(storage_checks), .request_in(request_in),
        .at_io_interface(at_io_interface), .iface_busy(iface_busy),
        .device_operating(device_operating), .chan_available(chan_available),
        .data_req_grant(data_req_grant), .block_requests(block_requests),
        .instr_strobe(instr_strobe), .instr_op(instr_op),
        .ctrl_check(ctrl_check), .cc_valid(cc_valid), .cond_code(cond_code),
        .id_store_strobe(id_store_strobe), .id_store_addr(id_store_addr),
        .id_store_data(id_store_data), .do_logout(do_logout),
        .do_csw_store(do_csw_store), .do_machine_reset(do_machine_reset),
        .do_selective_reset(do_selective_reset), .ret_valid(ret_valid),
        .ret_data(ret_data), .ret_checks(ret_checks));

    cpa_partner p_u (.clock(clock), .select_channel(select_channel),
        .intr_response(intr_response), .ctrl_transmit(ctrl_transmit),
        .instruction_code_bus(instruction_code_bus), .ctrl_bus(ctrl_bus),
        .storage_advance_strobe(storage_advance_strobe),
        .storage_return_data(storage_return_data),
        .storage_checks(storage_checks));

    // Pulse log, fixed order inside one cycle so same-cycle pulses compare
    always @(negedge clock) begin
        cyc++;
        if (cc_valid === 1'b1) cc_pulses++;
        ev = {ret_valid, id_store_strobe, ctrl_check, instr_strobe,
            do_machine_reset, do_csw_store, do_logout, do_selective_reset};
        for (int i = 0; i < 8; i++) begin
            if (ev[i] === 1'b1) begin
                log_q.push_back(i + 1);
                cyc_q.push_back(cyc);
            end
        end
        if (block_requests === 1'b1) saw_block = 1'b1;
        if (block_requests && blk_d && data_req_grant) bad_grant++;
        blk_d = block_requests;
    end

    function automatic int unsigned xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [3:0] exp_op(input logic [3:0] c);
        if (c == 4'he) return 4'h6;
        if (c == 4'hc) return 4'h4;
        return c;
    endfunction

    task automatic final_report();
        $display("comparisons %0d, miscompares %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Compare logged pulses with the model; step is the cycle spacing
    task automatic check_log(input int step);
        int n;
        n = 0;
        while (log_q.size() < exp_q.size() && n < 60) begin
            @(posedge clock);
            n++;
        end
        if (n >= 60) begin
            miscompares++;
            final_report();
        end
        repeat (3) @(negedge clock);
        `CHK("pulse count", exp_q.size(), log_q.size())
        foreach (exp_q[i]) begin
            if (i < log_q.size()) begin
                `CHK("pulse", exp_q[i], log_q[i])
                `CHK("spacing", i * step, cyc_q[i] - cyc_q[0])
            end
        end
        log_q.delete();
        cyc_q.delete();
    endtask

    task automatic wait_grant(input logic v);
        int n;
        n = 0;
        while (data_req_grant !== v && n < 40) begin
            @(negedge clock);
            n++;
        end
        `CHK("grant", v, data_req_grant)
        if (n >= 40) final_report();
    endtask

    initial begin
        repeat (4) @(posedge clock);
        `CHK("ret_valid in reset", 1'b0, ret_valid)
        rst_n <= 1'b1;
        repeat (2) @(negedge clock);
        `CHK("id addr", 8'ha8, id_store_addr)
        foreach (codes[i]) begin
            p_u.issue(codes[i], 1'b0, 1'b0, 3'h0);
            exp_q = '{5};
            if (codes[i] == 4'hf) exp_q.push_back(7);
            check_log(0);
            `CHK("op", exp_op(codes[i]), instr_op)
        end
        for (int i = 0; i < 3; i++) begin
            @(posedge clock);
            chan_available <= (i != 2);
            iface_busy <= (i == 1);
            p_u.issue(4'hf, 1'b0, 1'b0, 3'h0);
            exp_q = '{5};
            if (i == 0) exp_q.push_back(7);
            check_log(0);
            `CHK("cc", ccs[i], cond_code)
            `CHK("id word", 32'h1000_0000, id_store_data)
        end
        @(posedge clock);
        chan_available <= 1'b1;
        iface_busy <= 1'b0;
        p_u.issue(4'h4, 1'b1, 1'b0, 3'h0);
        exp_q = '{6};
        check_log(0);
        `CHK("cc", 2'h1, cond_code)
        `CHK("cc pulses", 5, cc_pulses)
        @(posedge clock);
        request_in <= 1'b1;
        wait_grant(1'b1);
        p_u.issue(4'h0, 1'b0, 1'b1, 3'h2);
        exp_q.delete();
        check_log(0);
        `CHK("blocked", 1'b1, saw_block)
        `CHK("grant in block", 0, bad_grant)
        `CHK("block end", 1'b0, block_requests)
        wait_grant(1'b1);
        @(posedge clock);
        force_instr <= 1'b1;
        wait_grant(1'b0);
        repeat (15) @(posedge clock);
        force_instr <= 1'b0;
        wait_grant(1'b1);
        @(posedge clock);
        request_in <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            @(posedge clock);
            at_io_interface <= i[0];
            if (i < 2) begin
                p_u.issue(4'h0, 1'b0, 1'b1, 3'h3);
            end else begin
                hang_detect <= 1'b1;
                repeat (20) @(posedge clock);
                hang_detect <= 1'b0;
            end
            if (i[0]) exp_q = '{1, 2, 3};
            else exp_q = '{2, 3, 4};
            check_log(1);
        end
        for (int i = 0; i < 3; i++) begin
            @(posedge clock);
            device_operating <= i[0];
            if (i == 0) begin
                p_u.issue(4'h0, 1'b0, 1'b1, 3'h4);
            end else begin
                chan_reset_pulse <= 1'b1;
                repeat (20) @(posedge clock);
                chan_reset_pulse <= 1'b0;
            end
            if (i == 2) exp_q = '{4};
            else exp_q = '{1, 4};
            check_log(0);
        end
        `CHK("cc cleared", 2'h0, cond_code)
        `CHK("op cleared", 4'h0, instr_op)
        for (int i = 0; i < 3; i++) begin
            rv = {xs(), xs(), xs()};
            dv = rv[71:0];
            cv = (i == 0) ? 4'h0 : rv[75:72];
            p_u.advance(dv, cv);
            exp_q = '{8};
            check_log(0);
            `CHK("ret data", dv, ret_data)
            `CHK("ret checks", cv, ret_checks)
        end
        final_report();
    end
endmodule
